//--- chip_select_cfg.svh
// constants for the bus chip select decoder: offsets, field positions,
// reset values and timing counts; definitions only
`ifndef CHIP_SELECT_CFG_SVH
`define CHIP_SELECT_CFG_SVH

// device count, block geometry and sync depth
`define CSD_DEV_COUNT     4
`define CSD_BLOCK_LSB     11
`define CSD_SPACE_BIT     15
`define CSD_HI_BLOCK_LSB  3
`define CSD_PORT_IDX_LSB  2
`define CSD_SYNC_DEPTH    2

// reset values
`define CSD_SEL_RST       4'h0
`define CSD_ADDR_RST      16'h0000
`define CSD_BYTE_RST      8'h00
`define CSD_STROBE_RST    1'b1

`endif

//--- chip_select_pkg.sv
// types shared by the bus chip select decoder
// assumes chip_select_cfg.svh is on the include path
`include "chip_select_cfg.svh"

package chip_select_pkg;

    // one bus cycle as seen by the decoder
    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_ADDR = 3'b010,
        PH_XFER = 3'b100
    } phase_type;

    // processor pins sampled together
    typedef struct packed {
        logic [7:0] ad;
        logic [7:0] addr_hi;
        logic       ale;
        logic       rd_n;
        logic       wr_n;
        logic       io_m;
        logic       mem_mapped;
        logic [1:0] style;
        logic       io_gate;
        logic [3:0] split;
    } pins_type;

    // whole decoder state
    typedef struct packed {
        pins_type   s1;
        pins_type   s2;
        logic       ale_prev;
        phase_type  phase;
        logic [15:0] addr;
        logic       io;
        logic [3:0] mem_sel;
        logic [3:0] port_sel;
    } state_type;

endpackage

//--- bus_chip_select_decoder.sv
// chip select decoder for a multiplexed 8-bit processor bus, 16-bit address
// assumes processor pins arrive asynchronously; one clock, async reset
//
// Overview of operation
// R1: memory-mapped: bit15 low memory, high ports
// R2: memory only in lower half, 32k bytes
// R3: direct load/store slower than port instructions
// R4: port space is 256 numbers, 8 bits
// R5: low 11 lines stay inside the device
// R6: full decode: bits 15..11 zero selects device
// R7: partial decode: bit11 low selects, aliases
// R8: never select two devices at once
// R9: selects qualified by strobe and latched address
// R10: ignore address outside a latched strobed cycle
// R11: each linear select bit halves address space
// R12: all-zero address selects program memory
// R13: shared enable: ports follow memory condition
// R14: processor raises io line only for ports
// R15: spare bits zero: memory 0-2k, ports 0-3; shared decode selects device 0 for ports 0-7
// R16: complete decode never enables two parts
// R17: steer separate port enables per device
// R18: bit15 driven io: ports at 32k, 128
// R19: gate memory-mapped enables with io low
// R20: hand peripherals latched low address bits
// R21: port number repeated on both address halves
// R22: latch low address byte at ale fall
// R23: register on ale fall, clear on reset
`include "chip_select_cfg.svh"
`timescale 1ns/100ps
`default_nettype none

module bus_chip_select_decoder (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [7:0]  ad_pins,
    input  wire logic [7:0]  addr_hi_pins,
    input  wire logic        ale,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic        io_m,
    input  wire logic        mem_mapped,
    input  wire logic [1:0]  decode_style,
    input  wire logic        io_gate,
    input  wire logic [3:0]  port_split,
    output logic      [3:0]  mem_sel,
    output logic      [3:0]  port_sel,
    output logic      [15:0] addr_latched,
    output logic             io_latched
);

    // ========================================================================
    // decode styles
    localparam logic [1:0] STYLE_FULL    = 2'b00;
    localparam logic [1:0] STYLE_PARTIAL = 2'b01;
    localparam logic [1:0] STYLE_LINEAR  = 2'b10;
    localparam int         NDEV          = `CSD_DEV_COUNT;
    localparam int         BLK           = `CSD_BLOCK_LSB;
    localparam int         TOP           = `CSD_SPACE_BIT;

    chip_select_pkg::state_type st_q;
    chip_select_pkg::state_type st_d;
    chip_select_pkg::pins_type  pins_now;

    logic        ale_fall;
    logic        strobe;
    logic [3:0]  mem_dec;
    logic [3:0]  port_dec;
    logic [3:0]  hi_dec;
    logic [3:0]  split_dec;
    logic [4:0]  hi_blk;
    logic [7:0]  port_num;

    // ========================================================================
    // pin gathering
    always_comb begin
        pins_now.ad         = ad_pins;
        pins_now.addr_hi    = addr_hi_pins;
        pins_now.ale        = ale;
        pins_now.rd_n       = rd_n;
        pins_now.wr_n       = wr_n;
        pins_now.io_m       = io_m;
        pins_now.mem_mapped = mem_mapped;
        pins_now.style      = decode_style;
        pins_now.io_gate    = io_gate;
        pins_now.split      = port_split;
    end

    // ale edge and strobe from the second sync stage only
    assign ale_fall = st_q.ale_prev & ~st_q.s2.ale;              // R22
    assign strobe   = ~st_q.s2.rd_n | ~st_q.s2.wr_n;             // R9

    // upper five address bits pick a 2k block; low 11 stay with the device
    assign hi_blk   = st_q.addr[TOP:BLK];                        // R5
    assign port_num = st_q.addr[7:0];                            // R4

    // ========================================================================
    // chip enable from the upper byte, shared by memory and port portions
    always_comb begin
        hi_dec = `CSD_SEL_RST;
        case (st_q.s2.style)
            STYLE_FULL: begin
                // block index must match and every higher bit be zero;
                // bit 15 is left to the space split when memory-mapped
                if (hi_blk[3:2] == 2'h0 && (st_q.s2.mem_mapped || !hi_blk[4])) begin
                    hi_dec[hi_blk[1:0]] = 1'b1;                  // R6
                end
            end
            STYLE_PARTIAL: begin
                // a single device on bit 11, aliased through the space
                hi_dec[0] = ~st_q.addr[BLK];                     // R7
            end
            STYLE_LINEAR: begin
                // lowest clear bit wins so no two parts share a cycle
                if (!st_q.addr[BLK]) begin
                    hi_dec[0] = 1'b1;                            // R11
                end else if (!st_q.addr[BLK+1]) begin
                    hi_dec[1] = 1'b1;
                end else if (!st_q.addr[BLK+2]) begin
                    hi_dec[2] = 1'b1;
                end else if (!st_q.addr[BLK+3]) begin
                    hi_dec[3] = 1'b1;
                end
            end
            default: begin
                hi_dec = `CSD_SEL_RST;
            end
        endcase
    end

    // independent port placement: each split device owns four port numbers
    generate
        for (genvar i = 0; i < NDEV; i++) begin : g_split
            assign split_dec[i] = st_q.s2.split[i] &
                (port_num[7:`CSD_PORT_IDX_LSB] == 6'(i));        // R17
        end
    endgenerate

    // ========================================================================
    // memory and port selection per addressing arrangement
    always_comb begin
        mem_dec  = `CSD_SEL_RST;
        port_dec = `CSD_SEL_RST;
        if (st_q.s2.mem_mapped) begin
            // io line low required when gating is on
            if (!(st_q.s2.io_gate && st_q.io)) begin             // R19
                if (!st_q.addr[TOP]) begin
                    mem_dec = hi_dec;                            // R1 R2
                end else begin
                    // ports at 32k and up, or port numbers 128 and up
                    port_dec = hi_dec;                           // R18
                end
            end
        end else if (st_q.io) begin
            // port number copied on both halves, so the upper byte decodes;
            // a split device that claims the number shuts out shared ones
            if (|split_dec) begin
                port_dec = split_dec;                            // R17 R8
            end else begin
                port_dec = hi_dec & ~st_q.s2.split;              // R13 R21
            end
        end else begin
            mem_dec = hi_dec;                                    // R12 R15
        end
    end

    // ========================================================================
    // next state: sync chain, cycle phase, latched address, selects
    // selects are recomputed each cycle and drop unless the cycle is strobed
    always_comb begin
        st_d          = st_q;
        st_d.s1       = pins_now;
        st_d.s2       = st_q.s1;
        st_d.ale_prev = st_q.s2.ale;
        st_d.mem_sel  = `CSD_SEL_RST;
        st_d.port_sel = `CSD_SEL_RST;
        case (st_q.phase)
            chip_select_pkg::PH_IDLE: begin
                if (ale_fall) begin
                    // capture the address before ad turns to data
                    st_d.addr  = {st_q.s2.addr_hi, st_q.s2.ad};  // R22 R23
                    st_d.io    = st_q.s2.io_m;
                    st_d.phase = chip_select_pkg::PH_ADDR;
                end
            end
            chip_select_pkg::PH_ADDR: begin
                if (st_q.s2.ale) begin
                    st_d.phase = chip_select_pkg::PH_IDLE;       // R10
                end else if (strobe) begin
                    st_d.phase = chip_select_pkg::PH_XFER;
                end
            end
            chip_select_pkg::PH_XFER: begin
                if (st_q.s2.ale || !strobe) begin
                    st_d.phase = chip_select_pkg::PH_IDLE;       // R10
                end else begin
                    st_d.mem_sel  = mem_dec;                     // R9
                    st_d.port_sel = port_dec;
                end
            end
            default: begin
                st_d.phase = chip_select_pkg::PH_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            st_q          <= '0;                                 // R23
            st_q.s1.rd_n  <= `CSD_STROBE_RST;
            st_q.s1.wr_n  <= `CSD_STROBE_RST;
            st_q.s2.rd_n  <= `CSD_STROBE_RST;
            st_q.s2.wr_n  <= `CSD_STROBE_RST;
            st_q.phase    <= chip_select_pkg::PH_IDLE;
            st_q.addr     <= `CSD_ADDR_RST;
            st_q.mem_sel  <= `CSD_SEL_RST;
            st_q.port_sel <= `CSD_SEL_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // outputs straight from flops
    assign mem_sel      = st_q.mem_sel;
    assign port_sel     = st_q.port_sel;
    assign addr_latched = st_q.addr;                             // R20
    assign io_latched   = st_q.io;

    // ========================================================================
    // assertions
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    a_no_double_sel: assert property ( // R8
        $onehot0({st_q.mem_sel, st_q.port_sel}))
        else $error("two devices selected at once");

    a_decode_exclusive: assert property ( // R16
        (st_q.phase == chip_select_pkg::PH_XFER) |=>
            $onehot0({st_q.mem_sel, st_q.port_sel}))
        else $error("decode enabled two parts");

    a_sel_needs_strobe: assert property ( // R9
        (|{st_q.mem_sel, st_q.port_sel}) |->
            $past(strobe) && $past(st_q.phase) == chip_select_pkg::PH_XFER)
        else $error("select without strobe in latched cycle");

    a_ale_drops_sel: assert property ( // R10
        st_q.s2.ale |=> (st_q.mem_sel == 4'h0) && (st_q.port_sel == 4'h0))
        else $error("select held while address changes");

    a_mem_low_half: assert property ( // R2
        (st_q.s2.mem_mapped && |st_q.mem_sel) |-> !st_q.addr[TOP])
        else $error("memory selected above 32k");

    a_port_high_half: assert property ( // R1
        (st_q.s2.mem_mapped && |st_q.port_sel) |-> st_q.addr[TOP])
        else $error("memory-mapped port below 32k");

    a_full_block_zero: assert property ( // R6
        (st_q.s2.style == STYLE_FULL && !st_q.s2.mem_mapped && st_q.mem_sel[0])
            |-> st_q.addr[TOP:BLK] == 5'h00)
        else $error("full decode block mismatch");

    a_partial_alias: assert property ( // R7
        (st_q.s2.style == STYLE_PARTIAL && |st_q.mem_sel)
            |-> st_q.mem_sel == 4'h1 && !st_q.addr[BLK])
        else $error("partial decode wrong select");

    a_io_gated: assert property ( // R19
        (st_q.s2.mem_mapped && st_q.s2.io_gate && |{st_q.mem_sel, st_q.port_sel})
            |-> !st_q.io)
        else $error("port instruction reached memory-mapped part");

    a_latch_capture: assert property ( // R22
        (st_q.phase == chip_select_pkg::PH_IDLE && ale_fall)
            |=> st_q.addr[7:0] == $past(st_q.s2.ad)
                && st_q.phase == chip_select_pkg::PH_ADDR)
        else $error("low address not latched at ale fall");

    a_boot_at_zero: assert property ( // R12
        (st_q.phase == chip_select_pkg::PH_XFER && strobe && !st_q.s2.ale
            && st_q.addr == 16'h0000 && !st_q.io && !st_q.s2.mem_mapped
            && st_q.s2.style != STYLE_LINEAR + 2'h1)
            |=> st_q.mem_sel[0])
        else $error("program memory not selected at zero");

    a_shared_port: assert property ( // R13
        (!st_q.s2.mem_mapped && st_q.port_sel[0] && !st_q.s2.split[0]
            && st_q.s2.style == STYLE_FULL) |-> st_q.addr[TOP:BLK] == 5'h00)
        else $error("shared port outside memory condition");

    a_linear_lowest: assert property ( // R11
        (st_q.s2.style == STYLE_LINEAR && st_q.mem_sel[1])
            |-> st_q.addr[BLK] && !st_q.addr[BLK+1])
        else $error("linear select skipped a lower clear bit");

    a_split_claims: assert property ( // R17
        (!st_q.s2.mem_mapped && st_q.port_sel[2] && st_q.s2.split[2])
            |-> st_q.addr[7:2] == 6'h02)
        else $error("split port outside its own numbers");

    a_shared_yields: assert property ( // R8
        (!st_q.s2.mem_mapped && |(st_q.port_sel & ~st_q.s2.split))
            |-> (st_q.port_sel & st_q.s2.split) == 4'h0)
        else $error("shared and split port selected together");

    a_latch_upper: assert property ( // R23
        (st_q.phase == chip_select_pkg::PH_IDLE && ale_fall)
            |=> st_q.addr[15:8] == $past(st_q.s2.addr_hi)
                && st_q.io == $past(st_q.s2.io_m))
        else $error("upper address or io not latched at ale fall");

    a_idle_no_sel: assert property ( // R10
        (st_q.phase != chip_select_pkg::PH_XFER)
            |=> (st_q.mem_sel == 4'h0) && (st_q.port_sel == 4'h0))
        else $error("select outside a strobed cycle");

    a_io_full_low: assert property ( // R13
        (!st_q.s2.mem_mapped && st_q.s2.style == STYLE_FULL
            && |(st_q.port_sel & ~st_q.s2.split)) |-> !st_q.addr[TOP])
        else $error("shared io-mapped port above port 127");

    // ========================================================================
    // cover points
    c_mem_read: cover property (
        st_q.phase == chip_select_pkg::PH_XFER ##1 st_q.mem_sel[0]);
    c_port_io: cover property (
        !st_q.s2.mem_mapped ##0 |st_q.port_sel);
    c_split_port: cover property (
        |(st_q.port_sel & st_q.s2.split));
    c_gate_block: cover property (
        st_q.s2.mem_mapped && st_q.s2.io_gate && st_q.io
            && st_q.phase == chip_select_pkg::PH_XFER);
    c_linear_top: cover property (
        st_q.s2.style == STYLE_LINEAR && st_q.mem_sel[3]);

endmodule

`default_nettype wire

//--- bus_master_model.sv
// processor bus master model: multiplexed address/data pins, strobes, io line
// assumes the testbench steps it through its tasks, one clock domain
`timescale 1ns/100ps
`default_nettype none

module bus_master_model (
    input  wire logic       clock,
    output logic      [7:0] ad_pins,
    output logic      [7:0] addr_hi_pins,
    output logic            ale,
    output logic            rd_n,
    output logic            wr_n,
    output logic            io_m
);
    // ==========================================================
    // idle pins at time zero
    initial begin
        ad_pins      = 8'h00;
        addr_hi_pins = 8'h00;
        ale          = 1'b0;
        rd_n         = 1'b1;
        wr_n         = 1'b1;
        io_m         = 1'b0;
    end

    // ==========================================================
    // address phase: ale pulse, then low byte replaced by data pattern
    task automatic address_phase(input logic [15:0] a, input logic io);
        @(posedge clock);
        addr_hi_pins <= io ? a[7:0] : a[15:8];
        ad_pins      <= a[7:0];
        io_m         <= io;
        ale          <= 1'b1;
        repeat (3) @(posedge clock);
        ale <= 1'b0;
        repeat (4) @(posedge clock);
        ad_pins <= ~a[7:0];
    endtask

    // strobe levels; on release bus shows inverse of last value
    task automatic set_strobe(input logic rd_low, input logic wr_low);
        @(posedge clock);
        rd_n <= ~rd_low;
        wr_n <= ~wr_low;
        if (!rd_low && !wr_low) begin
            ad_pins      <= ~ad_pins;
            addr_hi_pins <= ~addr_hi_pins;
            io_m         <= 1'b0;
        end
    endtask

    // raw ale level, for aborted cycles
    task automatic set_ale(input logic level);
        @(posedge clock);
        ale <= level;
    endtask
endmodule
`default_nettype wire

//--- bus_chip_select_decoder_test.sv
// self-checking bench for the bus chip select decoder
// assumes bus_master_model drives the processor pins
`timescale 1ns/100ps
`default_nettype none

module bus_chip_select_decoder_test;
    typedef struct packed {
        logic        mm;
        logic [1:0]  style;
        logic        gate;
        logic [3:0]  split;
        logic [15:0] addr;
        logic        io;
        logic [3:0]  mem;
        logic [3:0]  port;
    } row_type;

    logic        clock = 1'b0;
    logic        sys_rst;
    logic        mem_mapped;
    logic [1:0]  decode_style;
    logic        io_gate;
    logic [3:0]  port_split;
    wire  [7:0]  ad_pins;
    wire  [7:0]  addr_hi_pins;
    wire         ale;
    wire         rd_n;
    wire         wr_n;
    wire         io_m;
    logic [3:0]  mem_sel;
    logic [3:0]  port_sel;
    logic [15:0] addr_latched;
    logic        io_latched;
    int          bad_count = 0;
    int          total_checks = 0;

    // ==========================================================
    // decode table: straps, address, io, expected selects
    row_type rows [15] = '{
        '{1'b1, 2'h0, 1'b0, 4'h0, 16'h0000, 1'b0, 4'h1, 4'h0},
        '{1'b1, 2'h0, 1'b0, 4'h0, 16'h1800, 1'b0, 4'h8, 4'h0},
        '{1'b1, 2'h0, 1'b0, 4'h0, 16'h2000, 1'b0, 4'h0, 4'h0},
        '{1'b1, 2'h0, 1'b0, 4'h0, 16'h8800, 1'b0, 4'h0, 4'h2},
        '{1'b1, 2'h0, 1'b1, 4'h0, 16'h0000, 1'b1, 4'h0, 4'h0},
        '{1'b1, 2'h1, 1'b0, 4'h0, 16'h1000, 1'b0, 4'h1, 4'h0},
        '{1'b1, 2'h1, 1'b0, 4'h0, 16'h0800, 1'b0, 4'h0, 4'h0},
        '{1'b1, 2'h2, 1'b0, 4'h0, 16'h6800, 1'b0, 4'h2, 4'h0},
        '{1'b1, 2'h2, 1'b0, 4'h0, 16'h3800, 1'b0, 4'h8, 4'h0},
        '{1'b1, 2'h3, 1'b0, 4'h0, 16'h0000, 1'b0, 4'h0, 4'h0},
        '{1'b0, 2'h0, 1'b0, 4'h0, 16'h0303, 1'b1, 4'h0, 4'h1},
        '{1'b0, 2'h0, 1'b0, 4'h0, 16'h0000, 1'b0, 4'h1, 4'h0},
        '{1'b0, 2'h0, 1'b0, 4'hf, 16'h0505, 1'b1, 4'h0, 4'h2},
        '{1'b0, 2'h0, 1'b0, 4'h4, 16'h0909, 1'b1, 4'h0, 4'h4},
        '{1'b0, 2'h0, 1'b0, 4'h0, 16'h8181, 1'b1, 4'h0, 4'h0}
    };

    // clock, 8 ns period
    always #4 clock = ~clock;

    bus_master_model bus_u (
        .clock        (clock),
        .ad_pins      (ad_pins),
        .addr_hi_pins (addr_hi_pins),
        .ale          (ale),
        .rd_n         (rd_n),
        .wr_n         (wr_n),
        .io_m         (io_m)
    );

    bus_chip_select_decoder dut_u (
        .clock        (clock),
        .sys_rst      (sys_rst),
        .ad_pins      (ad_pins),
        .addr_hi_pins (addr_hi_pins),
        .ale          (ale),
        .rd_n         (rd_n),
        .wr_n         (wr_n),
        .io_m         (io_m),
        .mem_mapped   (mem_mapped),
        .decode_style (decode_style),
        .io_gate      (io_gate),
        .port_split   (port_split),
        .mem_sel      (mem_sel),
        .port_sel     (port_sel),
        .addr_latched (addr_latched),
        .io_latched   (io_latched)
    );

    // ==========================================================
    // compare tasks and verdict
    task automatic check_sel(input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch selects expected %h seen %h", exp, seen);
        end
    endtask

    task automatic check_addr(input logic [16:0] exp, input logic [16:0] seen);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch latched address expected %h seen %h", exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // one whole bus cycle with checks while strobed and after release
    task automatic run_cycle(input logic [15:0] a, input logic io, input logic wr,
                             input logic [3:0] em, input logic [3:0] ep);
        bus_u.address_phase(a, io);
        bus_u.set_strobe(~wr, wr);
        repeat (8) @(posedge clock);
        #1;
        check_sel({em, ep}, {mem_sel, port_sel});
        check_addr({io, a}, {io_latched, addr_latched});
        bus_u.set_strobe(1'b0, 1'b0);
        repeat (6) @(posedge clock);
        #1;
        check_sel(8'h00, {mem_sel, port_sel});
    endtask

    // ==========================================================
    // watchdog against a hang
    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        print_verdict();
    end

    // main sequence
    initial begin
        sys_rst      = 1'b1;
        mem_mapped   = 1'b1;
        decode_style = 2'h0;
        io_gate      = 1'b0;
        port_split   = 4'h0;
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        #1;
        check_sel(8'h00, {mem_sel, port_sel});
        check_addr(17'h00000, {io_latched, addr_latched});
        repeat (3) @(posedge clock);
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge clock);
            mem_mapped   <= rows[i].mm;
            decode_style <= rows[i].style;
            io_gate      <= rows[i].gate;
            port_split   <= rows[i].split;
            run_cycle(rows[i].addr, rows[i].io, i[0], rows[i].mem, rows[i].port);
            $display("test row %0d done", i);
        end
        // strobe with no address latch before it
        bus_u.set_strobe(1'b1, 1'b0);
        repeat (8) @(posedge clock);
        #1;
        check_sel(8'h00, {mem_sel, port_sel});
        bus_u.set_strobe(1'b0, 1'b0);
        repeat (6) @(posedge clock);
        $display("test no latch done");
        // ale rising in mid transfer aborts the selects
        @(posedge clock);
        mem_mapped <= 1'b1;
        port_split <= 4'h0;
        bus_u.address_phase(16'h0000, 1'b0);
        bus_u.set_strobe(1'b1, 1'b0);
        repeat (8) @(posedge clock);
        #1;
        check_sel(8'h10, {mem_sel, port_sel});
        bus_u.set_ale(1'b1);
        repeat (4) @(posedge clock);
        #1;
        check_sel(8'h00, {mem_sel, port_sel});
        bus_u.set_strobe(1'b0, 1'b0);
        bus_u.set_ale(1'b0);
        repeat (6) @(posedge clock);
        $display("test abort done");
        // reset in mid transfer, strobe still low after release
        bus_u.address_phase(16'h1800, 1'b0);
        bus_u.set_strobe(1'b0, 1'b1);
        repeat (8) @(posedge clock);
        #1;
        check_sel(8'h80, {mem_sel, port_sel});
        @(posedge clock);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        #1;
        check_sel(8'h00, {mem_sel, port_sel});
        check_addr(17'h00000, {io_latched, addr_latched});
        @(posedge clock);
        sys_rst <= 1'b0;
        repeat (8) @(posedge clock);
        #1;
        check_sel(8'h00, {mem_sel, port_sel});
        bus_u.set_strobe(1'b0, 1'b0);
        repeat (4) @(posedge clock);
        $display("test mid reset done");
        print_verdict();
    end
endmodule
`default_nettype wire
